// ==== hw/i2c_slave_pkg.sv ====
// shared constants, types and states for the i2c slave transceiver
package i2c_slave_pkg;

    // ----------------
    // widths
    // ----------------
    localparam int ADDR_WIDTH = 7;
    localparam int DATA_WIDTH = 8;
    localparam int TX_DEPTH = 2;

    // ----------------
    // counts and fixed values
    // ----------------
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;     // sent when no transmit byte is waiting
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic RELEASED = 1'b1;             // serial output level that leaves the line high
    localparam logic PULL_LOW = 1'b0;
    localparam logic LINE_IDLE = 1'b1;            // bus lines idle high
    localparam logic FLAG_RESET = 1'b0;

    // ----------------
    // types
    // ----------------
    typedef struct packed {
        logic scl;
        logic sda;
    } busLines_t;

    localparam busLines_t LINES_IDLE = '{scl: LINE_IDLE, sda: LINE_IDLE};

    typedef struct packed {
        logic transferValid;
        logic directionBit;
        logic dataPhase;
    } xferStatus_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WRITE,
        ST_WRITE_ACK,
        ST_READ,
        ST_READ_ACK,
        ST_HOLD
    } slaveState_t;

endpackage : i2c_slave_pkg

// ==== hw/bus_line_sync.sv ====
// two-stage synchroniser for the sampled bus clock and data lines
`timescale 1ns/10ps
module bus_line_sync
    import i2c_slave_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clkEn,
    // lines from the pins and their synchronised copies
    input wire busLines_t linesIn,
    output busLines_t linesOut
);

    busLines_t stage1_ff;
    busLines_t stage2_ff;

    // first stage is read only by the second one
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_ff <= LINES_IDLE;
            stage2_ff <= LINES_IDLE;
        end else if (clkEn) begin
            stage1_ff <= linesIn;
            stage2_ff <= stage1_ff;
        end
    end

    assign linesOut = stage2_ff;

endmodule : bus_line_sync

// ==== hw/tx_byte_buffer.sv ====
// small valid/ready buffer holding bytes waiting to be sent on reads
`timescale 1ns/10ps
module tx_byte_buffer
    import i2c_slave_pkg::*;
#(
    parameter int WIDTH = DATA_WIDTH,
    parameter int DEPTH = TX_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clkEn,
    // filling side
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    // draining side
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PTR_W:0] CNT_FULL = (PTR_W + 1)'(DEPTH);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PTR_W-1:0] wrPtr_ff;
    logic [PTR_W-1:0] rdPtr_ff;
    logic [PTR_W:0] count_ff;
    logic inReady_ff;
    logic outValid_ff;

    wire doPush = inValid && inReady_ff;
    wire doPop = outReady && outValid_ff;
    wire [PTR_W:0] nxt_count = count_ff + (PTR_W + 1)'(doPush) - (PTR_W + 1)'(doPop);

    function automatic logic [PTR_W-1:0] ptrStep(input logic [PTR_W-1:0] p);
        ptrStep = (p == PTR_LAST) ? '0 : p + PTR_W'(1);
    endfunction : ptrStep

    // ready and valid are registered from the next count, so both are honest flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
            inReady_ff <= 1'b1;
            outValid_ff <= 1'b0;
        end else if (clkEn) begin
            if (doPush) wrPtr_ff <= ptrStep(wrPtr_ff);
            if (doPop) rdPtr_ff <= ptrStep(rdPtr_ff);
            count_ff <= nxt_count;
            inReady_ff <= (nxt_count != CNT_FULL);
            outValid_ff <= (nxt_count != '0);
        end
    end

    // storage has no reset; entries are only read once written
    always_ff @(posedge clk) begin
        if (clkEn && doPush) mem_ff[wrPtr_ff] <= inData;
    end

    assign inReady = inReady_ff;
    assign outValid = outValid_ff;
    assign outData = mem_ff[rdPtr_ff];

endmodule : tx_byte_buffer

// ==== hw/i2c_slave_transceiver.sv ====
// i2c slave transceiver: serial bus to 8-bit parallel port, 7-bit address
//
// Functional notes
// RULE1: answer only a 7-bit address equal to the select pins.
// RULE2: serial to 8-bit parallel and back.
// RULE3: received byte valid only while the full flag is high.
// RULE4: full flag moves only on a bus clock fall; the code also clears it on resetIn, a start condition or a stop condition.
// RULE5: local logic takes the byte before the next gated fall.
// RULE6: slave only; no stretching, general call or ten-bit address.
// RULE7: any bus rate up to fast mode.
// RULE8: start flag on a start condition or reset input.
// RULE9: ack suppress keeps the ack off the data line.
// RULE10: transfer-valid rises on a matching address.
// RULE11: direction high for master read, low for write.
// RULE12: gated clock follows bus clock only while transfer valid; the code also lets it follow while testModeIn is high.
// RULE13: delayed direction is direction one clock later.
// RULE14: phase high in data phase, low in address phase.
// RULE15: transmit byte serialised during reads.
// RULE16: serial data on a dedicated output to a driver.
// RULE17: bus clock and data on two input pins.
// RULE18: serial output active low; high releases the line.
// RULE19: stop or mismatch returns idle, clears transfer-valid.
`timescale 1ns/10ps
module i2c_slave_transceiver
    import i2c_slave_pkg::*;
(
    // clock, reset and freeze
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clkEn,
    // bus side pins
    input wire logic busClockIn,
    input wire logic busDataIn,
    output logic serialOutLow,
    // control inputs from local logic
    input wire logic resetIn,
    input wire logic testModeIn,
    input wire logic ackSuppress,
    input wire logic [ADDR_WIDTH-1:0] addrSelect,
    // transmit bytes from local logic
    input wire logic [DATA_WIDTH-1:0] txData,
    input wire logic txValid,
    output logic txReady,
    // status and received data toward local logic
    output logic transferValid,
    output logic directionBit,
    output logic readDelayed,
    output logic dataPhase,
    output logic startSeen,
    output logic shiftFull,
    output logic [DATA_WIDTH-1:0] rxParallelOut,
    output logic gatedClk
);

    // ----------------
    // input synchronisation and edge finding
    // ----------------

    busLines_t pinLines;
    busLines_t syncLines;
    busLines_t prevLines_ff;

    // two separate pins, both pass two flops before any logic looks at them
    assign pinLines = '{scl: busClockIn, sda: busDataIn}; // see RULE17

    bus_line_sync u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .linesIn(pinLines),
        .linesOut(syncLines)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) prevLines_ff <= LINES_IDLE;
        else if (clkEn) prevLines_ff <= syncLines;
    end

    // at 10 MHz a fast-mode bit spans about 25 samples, so edges are never missed
    wire sclRise = syncLines.scl && !prevLines_ff.scl; // see RULE7
    wire sclFall = !syncLines.scl && prevLines_ff.scl;
    wire sclHigh = syncLines.scl && prevLines_ff.scl;
    wire startCond = sclHigh && prevLines_ff.sda && !syncLines.sda;
    wire stopCond = sclHigh && !prevLines_ff.sda && syncLines.sda;

    // ----------------
    // registers
    // ----------------

    slaveState_t state_ff;
    slaveState_t nxt_state;
    logic [3:0] bitCnt_ff;
    logic [3:0] nxt_bitCnt;
    logic [DATA_WIDTH-1:0] rxShift_ff;
    logic [DATA_WIDTH-1:0] nxt_rxShift;
    logic [DATA_WIDTH-1:0] txShift_ff;
    logic [DATA_WIDTH-1:0] nxt_txShift;
    logic [DATA_WIDTH-1:0] rxOut_ff;
    logic [DATA_WIDTH-1:0] nxt_rxOut;
    xferStatus_t status_ff;
    xferStatus_t nxt_status;
    logic serialOut_ff;
    logic nxt_serialOut;
    logic full_ff;
    logic nxt_full;
    logic masterAck_ff;
    logic nxt_masterAck;
    logic startSeen_ff;
    logic readDelayed_ff;
    logic gatedClk_ff;
    logic loadTx;

    // ----------------
    // transmit buffer
    // ----------------

    logic [DATA_WIDTH-1:0] bufData;
    logic bufValid;

    // two entries let local logic queue the next byte while one is on the wire
    tx_byte_buffer #(
        .WIDTH(DATA_WIDTH),
        .DEPTH(TX_DEPTH)
    ) u_txbuf (
        .clk(clk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .inData(txData),
        .inValid(txValid),
        .inReady(txReady),
        .outData(bufData),
        .outValid(bufValid),
        .outReady(loadTx)
    );

    // an empty buffer sends all ones, which simply leaves the line released
    wire [DATA_WIDTH-1:0] txByte = bufValid ? bufData : IDLE_BYTE;

    // ----------------
    // decoding
    // ----------------

    wire byteDone = (bitCnt_ff == BITS_PER_BYTE);
    wire addrMatch = (rxShift_ff[DATA_WIDTH-1:1] == addrSelect); // see RULE1
    wire rwBit = rxShift_ff[0];
    // acknowledge only pulls low when local logic allows it
    wire ackLevel = ackSuppress ? RELEASED : PULL_LOW; // see RULE9
    wire [3:0] bitCntInc = bitCnt_ff + 4'h1;

    function automatic logic [DATA_WIDTH-1:0] shiftIn(input logic [DATA_WIDTH-1:0] r,
                                                      input logic b);
        shiftIn = {r[DATA_WIDTH-2:0], b};
    endfunction : shiftIn

    // ----------------
    // protocol state machine
    // ----------------

    // slave changes its output only after a clock fall and samples on a rise;
    // it never holds the clock low, so no stretching is possible
    always_comb begin
        nxt_state = state_ff;
        nxt_bitCnt = bitCnt_ff;
        nxt_rxShift = rxShift_ff;
        nxt_txShift = txShift_ff;
        nxt_rxOut = rxOut_ff;
        nxt_status = status_ff;
        nxt_serialOut = serialOut_ff;
        nxt_full = full_ff;
        nxt_masterAck = masterAck_ff;
        loadTx = 1'b0;
        if (resetIn) begin
            nxt_state = ST_IDLE;
            nxt_bitCnt = BIT_CNT_RESET;
            nxt_status = '0;
            nxt_serialOut = RELEASED;
            nxt_full = FLAG_RESET;
        end else if (startCond) begin
            // repeated start also lands here and re-enters the address phase
            nxt_state = ST_ADDR;
            nxt_bitCnt = BIT_CNT_RESET;
            nxt_status = '0; // see RULE14
            nxt_serialOut = RELEASED;
            nxt_full = FLAG_RESET;
        end else if (stopCond) begin
            nxt_state = ST_IDLE; // see RULE19
            nxt_status = '0;
            nxt_serialOut = RELEASED;
            nxt_full = FLAG_RESET;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    nxt_serialOut = RELEASED;
                end
                ST_ADDR: begin
                    if (sclRise && !byteDone) begin
                        nxt_rxShift = shiftIn(rxShift_ff, syncLines.sda);
                        nxt_bitCnt = bitCntInc;
                    end else if (sclFall && byteDone) begin
                        // only 7-bit own address; general call and ten-bit are ignored
                        if (addrMatch) begin // see RULE6
                            nxt_state = ST_ADDR_ACK;
                            nxt_status.transferValid = 1'b1; // see RULE10
                            nxt_status.directionBit = rwBit; // see RULE11
                            nxt_serialOut = ackLevel;
                        end else begin
                            nxt_state = ST_IDLE; // see RULE19
                            nxt_status = '0;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (sclFall) begin
                        nxt_bitCnt = BIT_CNT_RESET;
                        nxt_status.dataPhase = 1'b1; // see RULE14
                        if (status_ff.directionBit) begin
                            nxt_state = ST_READ;
                            loadTx = 1'b1;
                            nxt_serialOut = txByte[DATA_WIDTH-1]; // see RULE15
                            nxt_txShift = {txByte[DATA_WIDTH-2:0], 1'b1};
                        end else begin
                            nxt_state = ST_WRITE;
                            nxt_serialOut = RELEASED;
                        end
                    end
                end
                ST_WRITE: begin
                    if (sclRise && !byteDone) begin
                        nxt_rxShift = shiftIn(rxShift_ff, syncLines.sda); // see RULE2
                        nxt_bitCnt = bitCntInc;
                    end else if (sclFall && byteDone) begin
                        // full flag up for one bus clock period; the byte stays on the parallel output until the next one
                        nxt_full = 1'b1; // see RULE3
                        nxt_rxOut = rxShift_ff;
                        nxt_state = ST_WRITE_ACK;
                        nxt_serialOut = ackLevel; // see RULE9
                    end
                end
                ST_WRITE_ACK: begin
                    if (sclFall) begin
                        nxt_full = FLAG_RESET; // see RULE4
                        nxt_bitCnt = BIT_CNT_RESET;
                        nxt_state = ST_WRITE;
                        nxt_serialOut = RELEASED;
                    end
                end
                ST_READ: begin
                    if (sclRise && !byteDone) begin
                        nxt_bitCnt = bitCntInc;
                    end else if (sclFall) begin
                        if (byteDone) begin
                            nxt_state = ST_READ_ACK;
                            nxt_serialOut = RELEASED;
                        end else begin
                            nxt_serialOut = txShift_ff[DATA_WIDTH-1]; // see RULE15
                            nxt_txShift = {txShift_ff[DATA_WIDTH-2:0], 1'b1};
                        end
                    end
                end
                ST_READ_ACK: begin
                    if (sclRise) begin
                        nxt_masterAck = !syncLines.sda;
                    end else if (sclFall) begin
                        nxt_bitCnt = BIT_CNT_RESET;
                        if (masterAck_ff) begin
                            nxt_state = ST_READ;
                            loadTx = 1'b1;
                            nxt_serialOut = txByte[DATA_WIDTH-1];
                            nxt_txShift = {txByte[DATA_WIDTH-2:0], 1'b1};
                        end else begin
                            // master said no more; wait released for its stop
                            nxt_state = ST_HOLD;
                            nxt_serialOut = RELEASED;
                        end
                    end
                end
                ST_HOLD: begin
                    nxt_serialOut = RELEASED;
                end
                default: begin
                    nxt_state = ST_IDLE;
                    nxt_status = '0;
                    nxt_serialOut = RELEASED;
                    nxt_full = FLAG_RESET;
                end
            endcase
        end
    end

    // ----------------
    // state and data flops
    // ----------------

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= ST_IDLE;
            bitCnt_ff <= BIT_CNT_RESET;
            rxShift_ff <= BYTE_RESET;
            txShift_ff <= IDLE_BYTE;
            rxOut_ff <= BYTE_RESET;
            status_ff <= '0;
            serialOut_ff <= RELEASED;
            full_ff <= FLAG_RESET;
            masterAck_ff <= FLAG_RESET;
        end else if (clkEn) begin
            state_ff <= nxt_state;
            bitCnt_ff <= nxt_bitCnt;
            rxShift_ff <= nxt_rxShift;
            txShift_ff <= nxt_txShift;
            rxOut_ff <= nxt_rxOut;
            status_ff <= nxt_status;
            serialOut_ff <= nxt_serialOut;
            full_ff <= nxt_full;
            masterAck_ff <= nxt_masterAck;
        end
    end

    // ----------------
    // side outputs
    // ----------------

    // start flag is a pulse per start, held high for as long as reset input is high
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) startSeen_ff <= FLAG_RESET;
        else if (clkEn) startSeen_ff <= startCond || resetIn; // see RULE8
    end

    // delayed copy of the registered direction bit
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) readDelayed_ff <= FLAG_RESET;
        else if (clkEn) readDelayed_ff <= status_ff.directionBit; // see RULE13
    end

    // gated clock idles low; test mode lets it run without a transfer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) gatedClk_ff <= FLAG_RESET;
        else if (clkEn) gatedClk_ff <= (status_ff.transferValid || testModeIn) && syncLines.scl; // see RULE12
    end

    // ----------------
    // output assignments
    // ----------------

    // dedicated output drives an external open-drain stage, no bidirectional pin here
    assign serialOutLow = serialOut_ff; // see RULE16 RULE18
    assign transferValid = status_ff.transferValid;
    assign directionBit = status_ff.directionBit;
    assign dataPhase = status_ff.dataPhase;
    assign readDelayed = readDelayed_ff;
    assign startSeen = startSeen_ff;
    assign shiftFull = full_ff;
    assign rxParallelOut = rxOut_ff;
    assign gatedClk = gatedClk_ff;

endmodule : i2c_slave_transceiver

// ==== dv/i2c_slave_checker.sv ====
// concurrent checks on the i2c slave transceiver ports
`timescale 1ns/10ps
module i2c_slave_checker (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // local controls
    input wire logic clkEn,
    input wire logic resetIn,
    input wire logic testModeIn,
    input wire logic ackSuppress,
    // status outputs
    input wire logic serialOutLow,
    input wire logic transferValid,
    input wire logic directionBit,
    input wire logic readDelayed,
    input wire logic dataPhase,
    input wire logic startSeen,
    input wire logic shiftFull,
    input wire logic gatedClk
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // ----------------
    // sequences
    // ----------------
    // a received byte stays up for at least half a bus period
    sequence s_fullHeld; shiftFull [*4]; endsequence
    sequence s_noXfer; (!transferValid && !testModeIn) [*2]; endsequence
    sequence s_localReset; resetIn && clkEn; endsequence
    // ----------------
    // properties
    // ----------------
    property p_delayedDir; clkEn && $past(clkEn) |-> readDelayed == $past(directionBit); endproperty
    a_delayedDir: assert property (p_delayedDir) else $error("delayed direction wrong");
    property p_gateIdle; s_noXfer |-> !gatedClk; endproperty
    a_gateIdle: assert property (p_gateIdle) else $error("gated clock runs while idle");
    property p_fullHeld; $rose(shiftFull) |-> s_fullHeld; endproperty
    a_fullHeld: assert property (p_fullHeld) else $error("full flag too short");
    property p_fullEdge; $changed(shiftFull) |-> ##1 !gatedClk; endproperty
    a_fullEdge: assert property (p_fullEdge) else $error("full flag moved off a fall");
    property p_fullWrite; $rose(shiftFull) |-> transferValid && dataPhase && !directionBit; endproperty
    a_fullWrite: assert property (p_fullWrite) else $error("byte outside a write");
    property p_startOnReset; s_localReset |-> ##[1:2] startSeen; endproperty
    a_startOnReset: assert property (p_startOnReset) else $error("no start flag on reset");
    property p_resetIdle; s_localReset |-> ##[1:2] !transferValid; endproperty
    a_resetIdle: assert property (p_resetIdle) else $error("transfer kept over reset");
    property p_ackHeld; (ackSuppress && !directionBit) [*2] |-> serialOutLow; endproperty
    a_ackHeld: assert property (p_ackHeld) else $error("ack driven while suppressed");
    property p_driveMatched; $fell(serialOutLow) |-> ##[0:1] transferValid; endproperty
    a_driveMatched: assert property (p_driveMatched) else $error("line pulled unmatched");
    property p_phaseValid; $rose(dataPhase) |-> transferValid; endproperty
    a_phaseValid: assert property (p_phaseValid) else $error("data phase without match");
    property p_validFirst; $rose(transferValid) |-> !dataPhase; endproperty
    a_validFirst: assert property (p_validFirst) else $error("match seen in data phase");
endmodule : i2c_slave_checker

bind i2c_slave_transceiver i2c_slave_checker chk (
    .clk(clk), .reset_n(reset_n), .clkEn(clkEn), .resetIn(resetIn), .testModeIn(testModeIn),
    .ackSuppress(ackSuppress), .serialOutLow(serialOutLow), .transferValid(transferValid),
    .directionBit(directionBit), .readDelayed(readDelayed), .dataPhase(dataPhase),
    .startSeen(startSeen), .shiftFull(shiftFull), .gatedClk(gatedClk)
);

// ==== dv/i2c_master_model.sv ====
// behavioural i2c bus master pacing its lines from the system clock
`timescale 1ns/10ps
module i2c_master_model (
    // pacing clock
    input wire logic clk,
    // data line as seen on the bus
    input wire logic sdaWire,
    // lines driven by the master; a released data line reads high
    output logic sclLine,
    output logic sdaOut
);
    // the bus clock stands still, high, between frames
    initial begin
        sclLine = 1'b1;
        sdaOut = 1'b1;
    end
    // one bit: four cycles low, four high, 800 ns; read late so the slave has settled
    task automatic bitX(input logic b, output logic got);
        sdaOut <= b;
        repeat (2) @(posedge clk);
        sclLine <= 1'b1;
        repeat (3) @(posedge clk);
        got = sdaWire;
        @(posedge clk);
        sclLine <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : bitX
    // data moves while the clock is high: start is (1,0), stop is (0,1)
    task automatic cond(input logic first, input logic last);
        @(posedge clk);
        sdaOut <= first;
        repeat (2) @(posedge clk);
        sclLine <= 1'b1;
        repeat (4) @(posedge clk);
        sdaOut <= last;
        repeat (4) @(posedge clk);
        if (!last) begin
            sclLine <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask : cond
    // eight bits msb first, then the ack slot in rx[0]
    task automatic byteX(input logic [7:0] tx, input logic lastBit, output logic [8:0] rx);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bitX(tx[i], g);
            rx[i + 1] = g;
        end
        bitX(lastBit, g);
        rx[0] = g;
    endtask : byteX
endmodule : i2c_master_model

// ==== dv/i2c_slave_transceiver_bench.sv ====
// self-checking bench for the i2c slave transceiver
`timescale 1ns/10ps
module i2c_slave_transceiver_bench
    import i2c_slave_pkg::*;
;
    localparam logic [6:0] OWN_ADDR = 7'h5A;
    localparam logic [6:0] MISS_ADDR [3] = '{7'h5B, 7'h00, 7'h78};
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic clkEn = 1'b1;
    logic resetIn = 1'b0;
    logic testModeIn = 1'b0;
    logic ackSuppress = 1'b0;
    logic txValid = 1'b0;
    logic [ADDR_WIDTH-1:0] addrSelect = OWN_ADDR;
    logic [DATA_WIDTH-1:0] txData = 8'h00;
    logic [DATA_WIDTH-1:0] rxParallelOut;
    logic txReady, serialOutLow, transferValid, directionBit, readDelayed;
    logic dataPhase, startSeen, shiftFull, gatedClk, sclLine, sdaOut, busDataIn;
    int miscompares = 0;
    int comparisons = 0;
    int startCount = 0;
    // 100 ns system clock
    initial begin
        forever #50 clk = ~clk;
    end
    i2c_slave_transceiver DUT (.clk(clk), .reset_n(reset_n), .clkEn(clkEn),
        .busClockIn(sclLine), .busDataIn(busDataIn), .serialOutLow(serialOutLow),
        .resetIn(resetIn), .testModeIn(testModeIn), .ackSuppress(ackSuppress),
        .addrSelect(addrSelect), .txData(txData), .txValid(txValid), .txReady(txReady),
        .transferValid(transferValid), .directionBit(directionBit), .readDelayed(readDelayed),
        .dataPhase(dataPhase), .startSeen(startSeen), .shiftFull(shiftFull),
        .rxParallelOut(rxParallelOut), .gatedClk(gatedClk));
    i2c_master_model master (.clk(clk), .sdaWire(busDataIn), .sclLine(sclLine),
        .sdaOut(sdaOut));
    // wired-and data line with pull-up
    assign busDataIn = sdaOut & serialOutLow;
    // count start pulses
    always @(negedge clk) begin
        if (startSeen === 1'b1) startCount <= startCount + 1;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        if (miscompares == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up
    // one byte offered for transmission, held for a single edge
    task automatic push(input logic [7:0] b);
        @(posedge clk);
        txData <= b;
        txValid <= 1'b1;
        @(posedge clk);
        txValid <= 1'b0;
    endtask : push
    task automatic t_write(input logic sup);
        logic [8:0] r;
        logic [7:0] got;
        int c0;
        c0 = startCount;
        got = 8'h00;
        @(posedge clk);
        ackSuppress <= sup;
        master.cond(1'b1, 1'b0);
        master.byteX({OWN_ADDR, 1'b0}, 1'b1, r);
        @(negedge clk);
        check({5'h00, transferValid, directionBit, r[0]}, {7'h02, sup});
        check(8'(startCount - c0), 8'h01);
        fork
            master.byteX(8'hA5, 1'b1, r);
            begin
                for (int n = 0; n < 200 && shiftFull !== 1'b1; n++) @(negedge clk);
                got = rxParallelOut;
            end
        join
        check(got, 8'hA5);
        check({5'h00, transferValid, dataPhase, r[0]}, {7'h03, sup});
        master.cond(1'b0, 1'b1);
        repeat (4) @(negedge clk);
        check({6'h00, transferValid, dataPhase}, 8'h00);
        @(posedge clk);
        ackSuppress <= 1'b0;
    endtask : t_write
    task automatic t_miss();
        logic [8:0] r;
        foreach (MISS_ADDR[i]) begin
            master.cond(1'b1, 1'b0);
            master.byteX({MISS_ADDR[i], 1'b0}, 1'b1, r);
            @(negedge clk);
            check({6'h00, transferValid, r[0]}, 8'h01);
            master.cond(1'b0, 1'b1);
        end
    endtask : t_miss
    // two bytes fill the buffer, a third is refused; the empty buffer then sends the idle byte
    task automatic t_read();
        logic [8:0] r;
        push(8'h3C);
        push(8'hC3);
        push(8'h77);
        @(negedge clk);
        check({7'h00, txReady}, 8'h00);
        master.cond(1'b1, 1'b0);
        master.byteX({OWN_ADDR, 1'b1}, 1'b1, r);
        @(negedge clk);
        check({5'h00, r[0], directionBit, readDelayed}, 8'h03);
        master.byteX(8'hFF, 1'b0, r);
        check(r[8:1], 8'h3C);
        master.byteX(8'hFF, 1'b0, r);
        check(r[8:1], 8'hC3);
        master.byteX(8'hFF, 1'b1, r);
        check(r[8:1], IDLE_BYTE);
        master.cond(1'b0, 1'b1);
        @(negedge clk);
        check({7'h00, txReady}, 8'h01);
    endtask : t_read
    // local reset in the middle of a matched transfer
    task automatic t_abort();
        logic [8:0] r;
        master.cond(1'b1, 1'b0);
        master.byteX({OWN_ADDR, 1'b0}, 1'b1, r);
        resetIn <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check({6'h00, startSeen, transferValid}, 8'h02);
        @(posedge clk);
        resetIn <= 1'b0;
        master.cond(1'b0, 1'b1);
    endtask : t_abort
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        check({serialOutLow, txReady, transferValid, dataPhase, shiftFull, gatedClk, 2'h0}, 8'hC0);
        t_write(1'b0);
        t_write(1'b1);
        t_miss();
        t_read();
        t_abort();
        wrap_up();
    end
    // watchdog
    initial begin
        repeat (8000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
endmodule : i2c_slave_transceiver_bench
